// File: cst_pkg.sv
/*
  Constants for the calibration status and trigger register bank: register
  indices, field positions, reset values, timing figures and the interrupt
  bit layout. Assumes an APB slave with 32-bit data and word-aligned registers.
*/
// Contract
// - Foreground complete set on finish or skip
// - Background halted reads 1 at halt
// - Background halted clears when calibration resumes
// - Background off: halted set by foreground end
// - Status pin select routes one of four
// - Select 0: software bit, pin ignored
// - Select 1: hardware pin, bit ignored
// - Software bit acts as pin, resets high
// - Low-power register resets to 0x88 fields
// - Trigger-wake: sleep until trigger low
// - Low-power enable needs background calibration
// - Sleep delay counted in 256-clock units
package cst_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATE    = 10'h06a;
  localparam logic [9:0] IDX_PIN      = 10'h06b;
  localparam logic [9:0] IDX_SOFT     = 10'h06c;
  localparam logic [9:0] IDX_LP       = 10'h06e;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h070;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h071;
  // State register fields
  localparam int unsigned ST_FG_POS   = 0;
  localparam int unsigned ST_HALT_POS = 1;
  localparam int unsigned ST_CODE_LSB = 2;
  // Pin setup fields and reset
  localparam int unsigned PIN_TSEL_POS = 0;
  localparam int unsigned PIN_SEL_LSB  = 1;
  localparam logic [7:0]  PIN_RESET    = 8'h00;
  // Software trigger reset: trigger held high
  localparam logic        SOFT_RESET   = 1'b1;
  // Low-power register fields and reset
  localparam int unsigned LP_ENABLE_POS = 0;
  localparam int unsigned LP_TWAKE_POS  = 1;
  localparam int unsigned LP_WAKE_LSB  = 3;
  localparam int unsigned LP_SLEEP_LSB = 5;
  localparam logic [7:0]  LP_RESET     = 8'h88;
  // Interrupt bits: foreground done, background halted, wake calibration
  localparam int unsigned IRQ_W        = 3;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;
  // Status pin select codes
  typedef enum logic [1:0] {
    CST_SEL_FG, CST_SEL_HALT, CST_SEL_ALARM, CST_SEL_LOW
  } cst_sel_t;
  // Delays counted in units of this many clock periods
  localparam int unsigned UNIT_CLOCKS  = 256;
  // Largest delay exponent in the sleep table
  localparam int unsigned EXP_MAX      = 33;
  localparam int unsigned CNT_W        = 35;
endpackage

// File: cst_sync.sv
/*
  Three-stage synchroniser for one asynchronous pin level.
  Assumes a free-running clk_i; the output moves only when stages two and
  three agree, so a one-stage glitch never reaches the core.
*/
`timescale 1ns/100ps
module cst_sync
  import cst_pkg::*;
(
  input  wire logic clk_i,    // Core clock
  input  wire logic rst_b_i,  // Async reset, active low
  input  wire logic pin_i,    // Raw pin level
  input  wire logic rst_val_i,// Unused-safe: level taken after release
  output logic      level_o   // Filtered level
);
  logic [2:0] stg_reg;   // Sync chain
  logic [2:0] stg_next;
  logic       lvl_reg;   // Agreed level
  logic       lvl_next;
  logic       init_reg;  // Level seeded once after reset release
  logic       init_next;

  // Shift chain and update level on agreement
  always_comb
  begin
    stg_next  = {stg_reg[1:0], pin_i};
    init_next = 1'b1;
    lvl_next  = lvl_reg;
    if (!init_reg)
    begin
      lvl_next = rst_val_i;
    end
    else if (stg_reg[1] == stg_reg[2])
    begin
      lvl_next = stg_reg[2];
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stg_reg  <= 3'h7;  // Pin idles high; no false low after release
      lvl_reg  <= 1'b1;
      init_reg <= 1'b0;
    end
    else
    begin
      stg_reg  <= stg_next;
      lvl_reg  <= lvl_next;
      init_reg <= init_next;
    end
  end

  assign level_o = lvl_reg;
endmodule

// File: cst_sleep_timer.sv
/*
  Low-power background sleep and wake sequencer for one converter core.
  Assumes core_sleep_i pulses when the core goes to sleep; delays are
  (2^k + 1) units of UNIT_CYCLES clocks, exponent capped by EXP_CAP.
*/
`timescale 1ns/100ps
module cst_sleep_timer
  import cst_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = UNIT_CLOCKS,
  parameter int unsigned EXP_CAP     = EXP_MAX
)
(
  input  wire logic       clk_i,       // Core clock
  input  wire logic       rst_b_i,     // Async reset, active low
  input  wire logic       active_i,    // Low-power calibration in force
  input  wire logic       trig_mode_i, // Sleep until trigger low
  input  wire logic [2:0] sleep_sel_i, // Sleep delay code
  input  wire logic [1:0] wake_sel_i,  // Wake delay code
  input  wire logic       trigger_i,   // Calibration trigger level
  input  wire logic       core_sleep_i,// Core entered sleep
  output logic            asleep_o,    // Core held asleep
  output logic            cal_go_o     // Pulse: start calibration
);
  typedef enum logic [1:0] { CST_IDLE, CST_SLEEP, CST_WAKE } cst_lp_t;

  cst_lp_t            st_reg;   // Sequencer state
  cst_lp_t            st_next;
  logic [CNT_W-1:0]   cnt_reg;  // Units remaining
  logic [CNT_W-1:0]   cnt_next;
  logic [8:0]         div_reg;  // Unit divider
  logic [8:0]         div_next;
  logic               tick;     // One pulse per unit
  logic               go_next;
  logic               go_reg;

  // Delay length in units for an exponent, capped for simulation
  function automatic logic [CNT_W-1:0] units(input int unsigned e);
    int unsigned k;
    k = (e > EXP_CAP) ? EXP_CAP : e;
    units = (CNT_W'(1) << k) + CNT_W'(1);
  endfunction

  // Sleep table exponents
  function automatic int unsigned sleep_exp(input logic [2:0] c);
    case (c)
      3'h0:    sleep_exp = 3;
      3'h1:    sleep_exp = 15;
      3'h2:    sleep_exp = 18;
      3'h3:    sleep_exp = 18;
      3'h4:    sleep_exp = 21;
      3'h5:    sleep_exp = 27;
      3'h6:    sleep_exp = 30;
      default: sleep_exp = 33;
    endcase
  endfunction

  // Wake table exponents
  function automatic int unsigned wake_exp(input logic [1:0] c);
    case (c)
      2'h0:    wake_exp = 3;
      2'h1:    wake_exp = 18;
      2'h2:    wake_exp = 21;
      default: wake_exp = 24;
    endcase
  endfunction

  // Unit divider and sequencer
  always_comb
  begin
    tick     = (div_reg == 9'(UNIT_CYCLES - 1));
    div_next = tick ? 9'h0 : div_reg + 9'h1;
    st_next  = st_reg;
    cnt_next = cnt_reg;
    go_next  = 1'b0;
    case (st_reg)
      CST_IDLE:
      begin
        if (active_i && core_sleep_i)
        begin
          st_next  = CST_SLEEP;
          cnt_next = units(sleep_exp(sleep_sel_i));
        end
      end
      CST_SLEEP:
      begin
        if (trig_mode_i)
        begin
          if (!trigger_i)
          begin
            st_next  = CST_WAKE;
            cnt_next = units(wake_exp(wake_sel_i));
          end
        end
        else if (tick)
        begin
          cnt_next = cnt_reg - CNT_W'(1);
          if (cnt_reg == CNT_W'(1))
          begin
            st_next  = CST_WAKE;
            cnt_next = units(wake_exp(wake_sel_i));
          end
        end
      end
      CST_WAKE:
      begin
        if (tick)
        begin
          cnt_next = cnt_reg - CNT_W'(1);
          if (cnt_reg == CNT_W'(1))
          begin
            st_next = CST_IDLE;
            go_next = 1'b1;
          end
        end
      end
      default: st_next = CST_IDLE;
    endcase
    if (!active_i)
    begin
      st_next = CST_IDLE;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg  <= CST_IDLE;
      cnt_reg <= '0;
      div_reg <= 9'h0;
      go_reg  <= 1'b0;
    end
    else
    begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      go_reg  <= go_next;
    end
  end

  assign asleep_o = (st_reg == CST_SLEEP);
  assign cal_go_o = go_reg;

  // Trigger-wake holds sleep while trigger high
  chk_trig_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_reg == CST_SLEEP && trig_mode_i && trigger_i && active_i) |=> (st_reg == CST_SLEEP))
    else $error("sleep left while trigger high");
endmodule

// File: cst_regs.sv
/*
  Calibration status, trigger source and low-power register bank with an
  APB slave, status pin routing and a sticky interrupt.
  Assumes the calibration core drives one-cycle event pulses on clk_i and
  the trigger pin is asynchronous.
*/
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module cst_regs
  import cst_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = cst_pkg::UNIT_CLOCKS,
  parameter int unsigned EXP_CAP     = cst_pkg::EXP_MAX
)
(
  input  wire logic                      clk_i,       // 25 MHz clock
  input  wire logic                      rst_b_i,     // Async reset, active low
  input  wire logic                      psel_i,      // APB select
  input  wire logic                      penable_i,   // APB enable
  input  wire logic                      pwrite_i,    // APB direction
  input  wire logic [cst_pkg::ADDR_W-1:0] paddr_i,    // APB byte address
  input  wire logic [cst_pkg::DATA_W-1:0] pwdata_i,   // APB write data
  output logic      [cst_pkg::DATA_W-1:0] prdata_o,   // APB read data
  output logic                           pready_o,    // APB ready
  output logic                           pslverr_o,   // APB error
  input  wire logic                      fg_complete_i,   // Foreground finished
  input  wire logic                      fg_skipped_i,    // Foreground skipped
  input  wire logic                      fg_restart_i,    // Calibration rerun
  input  wire logic                      bg_halt_reached_i,// Halted at phase
  input  wire logic                      bg_resume_i,     // Calibration resumes
  input  wire logic                      background_calibration_enable_i,
  input  wire logic [2:0]                cal_state_code_i,// Core state code
  input  wire logic                      alarm_i,         // Alarm flag
  input  wire logic                      core_sleep_i,    // Core went asleep
  input  wire logic                      hardware_trigger_input_i, // Pin
  output logic                           calibration_status_output_o,
  output logic                           cal_trigger_o,   // Selected trigger
  output logic                           lowpower_active_o,
  output logic                           core_asleep_o,
  output logic                           core_calibrate_o,// Pulse
  output logic                           irq_o            // Level interrupt
);
  // Status flags
  logic            foreground_complete_reg;     // Foreground complete
  logic            foreground_complete_next;
  logic            halted_reg;      // Background halted
  logic            halted_next;
  // Software registers
  logic            tsel_reg;        // Trigger source select
  logic            tsel_next;
  logic [1:0]      psel_reg;        // Status pin select
  logic [1:0]      psel_next;
  logic            soft_reg;        // Software trigger bit
  logic            soft_next;
  logic [7:0]      lp_reg;          // Low-power setup
  logic [7:0]      lp_next;
  logic [IRQ_W-1:0] ist_reg;        // Interrupt status
  logic [IRQ_W-1:0] ist_next;
  logic [IRQ_W-1:0] imask_reg;      // Interrupt mask
  logic [IRQ_W-1:0] imask_next;
  // Bus read path
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic            hit_reg;         // Address decoded in setup
  logic            hit_next;
  logic            pin_reg;         // Status pin
  logic            pin_next;
  // Helpers
  logic            hw_trig;         // Synchronised pin
  logic            fg_set;
  logic            halt_set;
  logic            lp_go;
  logic            setup;
  logic            wr;
  logic [IRQ_W-1:0] ev;

  // Register index from a byte address
  function automatic logic [9:0] idx(input logic [ADDR_W-1:0] a);
    idx = a[ADDR_W-1:2];
  endfunction

  // Known register at an index
  function automatic logic mapped(input logic [9:0] i);
    mapped = (i == IDX_STATE) || (i == IDX_PIN) || (i == IDX_SOFT) ||
             (i == IDX_LP) || (i == IDX_IRQ_STAT) || (i == IDX_IRQ_MASK);
  endfunction

  // Trigger pin synchroniser
  // Pin idles high, so the filtered level is seeded high
  cst_sync u_sync (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (hardware_trigger_input_i),
    .rst_val_i (1'b1),
    .level_o   (hw_trig)
  );

  // Trigger source mux
  assign cal_trigger_o = tsel_reg ? hw_trig : soft_reg;

  // Low-power enable gated by background calibration
  assign lowpower_active_o = lp_reg[LP_ENABLE_POS] & background_calibration_enable_i;

  // Sleep and wake sequencer
  cst_sleep_timer #(
    .UNIT_CYCLES (UNIT_CYCLES),
    .EXP_CAP     (EXP_CAP)
  ) u_timer (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .active_i     (lowpower_active_o),
    .trig_mode_i  (lp_reg[LP_TWAKE_POS]),
    .sleep_sel_i  (lp_reg[LP_SLEEP_LSB +: 3]),
    .wake_sel_i   (lp_reg[LP_WAKE_LSB +: 2]),
    .trigger_i    (cal_trigger_o),
    .core_sleep_i (core_sleep_i),
    .asleep_o     (core_asleep_o),
    .cal_go_o     (lp_go)
  );

  // Status flag updates
  always_comb
  begin
    fg_set   = fg_complete_i | fg_skipped_i;
    halt_set = bg_halt_reached_i | (!background_calibration_enable_i & fg_set);
    foreground_complete_next = foreground_complete_reg;
    if (fg_set)
    begin
      foreground_complete_next = 1'b1;
    end
    else if (fg_restart_i)
    begin
      foreground_complete_next = 1'b0;
    end
    halted_next = halted_reg;
    if (halt_set)
    begin
      halted_next = 1'b1;
    end
    else if (bg_resume_i)
    begin
      halted_next = 1'b0;
    end
  end

  // Status pin routing
  always_comb
  begin
    case (cst_sel_t'(psel_reg))
      CST_SEL_FG:    pin_next = foreground_complete_reg;
      CST_SEL_HALT:  pin_next = halted_reg;
      CST_SEL_ALARM: pin_next = alarm_i;
      default:       pin_next = 1'b0;
    endcase
  end

  // Software register writes and interrupt status
  always_comb
  begin
    setup      = psel_i & ~penable_i;
    wr         = psel_i & penable_i & pwrite_i;
    tsel_next  = tsel_reg;
    psel_next  = psel_reg;
    soft_next  = soft_reg;
    lp_next    = lp_reg;
    imask_next = imask_reg;
    ev         = {lp_go, halt_set, fg_set};
    ist_next   = ist_reg;
    if (wr)
    begin
      case (idx(paddr_i))
        IDX_PIN:
        begin
          tsel_next = pwdata_i[PIN_TSEL_POS];
          psel_next = pwdata_i[PIN_SEL_LSB +: 2];
        end
        IDX_SOFT:     soft_next  = pwdata_i[0];
        IDX_LP:       lp_next    = {pwdata_i[7:3], 1'b0, pwdata_i[1:0]};
        IDX_IRQ_STAT: ist_next   = ist_reg & ~pwdata_i[IRQ_W-1:0];
        IDX_IRQ_MASK: imask_next = pwdata_i[IRQ_W-1:0];
        default:      ist_next   = ist_reg; // State register ignores writes
      endcase
    end
    // Events win over a same-cycle clear
    ist_next = ist_next | ev;
  end

  // Read data captured in the setup cycle
  always_comb
  begin
    hit_next   = hit_reg;
    rdata_next = rdata_reg;
    if (setup)
    begin
      hit_next   = mapped(idx(paddr_i));
      rdata_next = '0;
      case (idx(paddr_i))
        IDX_STATE:
        begin
          rdata_next[ST_CODE_LSB +: 3] = cal_state_code_i;
          rdata_next[ST_HALT_POS]      = halted_reg;
          rdata_next[ST_FG_POS]        = foreground_complete_reg;
        end
        IDX_PIN:
        begin
          rdata_next[PIN_TSEL_POS]     = tsel_reg;
          rdata_next[PIN_SEL_LSB +: 2] = psel_reg;
        end
        IDX_SOFT:     rdata_next[0]            = soft_reg;
        IDX_LP:       rdata_next[7:0]          = lp_reg;
        IDX_IRQ_STAT: rdata_next[IRQ_W-1:0]    = ist_reg;
        IDX_IRQ_MASK: rdata_next[IRQ_W-1:0]    = imask_reg;
        default:      rdata_next               = '0;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      foreground_complete_reg <= 1'b0;
      halted_reg  <= 1'b0;
      tsel_reg    <= PIN_RESET[PIN_TSEL_POS];
      psel_reg    <= PIN_RESET[PIN_SEL_LSB +: 2];
      soft_reg    <= SOFT_RESET;
      lp_reg      <= LP_RESET;
      ist_reg     <= IRQ_RESET;
      imask_reg   <= IRQ_RESET;
      rdata_reg   <= '0;
      hit_reg     <= 1'b0;
      pin_reg     <= 1'b0;
    end
    else
    begin
      foreground_complete_reg <= foreground_complete_next;
      halted_reg  <= halted_next;
      tsel_reg    <= tsel_next;
      psel_reg    <= psel_next;
      soft_reg    <= soft_next;
      lp_reg      <= lp_next;
      ist_reg     <= ist_next;
      imask_reg   <= imask_next;
      rdata_reg   <= rdata_next;
      hit_reg     <= hit_next;
      pin_reg     <= pin_next;
    end
  end

  // Bus and pin outputs
  assign prdata_o  = rdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_reg;
  assign calibration_status_output_o = pin_reg;
  assign irq_o     = |(ist_reg & imask_reg);
  // Calibration start pulse from the sleep timer
  assign core_calibrate_o = lp_go;

  // Checks on this clock and reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_foreground_complete_set: assert property ((fg_complete_i || fg_skipped_i) |=> foreground_complete_reg)
    else $error("foreground complete not set");
  chk_halt_set: assert property (bg_halt_reached_i |=> halted_reg ##1 (halted_reg || $past(bg_resume_i)))
    else $error("halted flag not held");
  chk_halt_clear: assert property ((bg_resume_i && !halt_set) |=> !halted_reg)
    else $error("halted flag not cleared on resume");
  chk_halt_bg_off: assert property ((!background_calibration_enable_i && fg_skipped_i) |=> halted_reg)
    else $error("halted flag not set by foreground end");
  chk_state_read: assert property ((setup && idx(paddr_i) == IDX_STATE) |=>
      (prdata_o[ST_CODE_LSB +: 3] == $past(cal_state_code_i) && prdata_o[7:5] == 3'h0))
    else $error("state read mismatch");
  chk_pin_low: assert property ((psel_reg == 2'h3) |=> !calibration_status_output_o)
    else $error("status pin not forced low");
  chk_pin_fg: assert property ((psel_reg == 2'h0) ##1 (psel_reg == 2'h0) |->
      calibration_status_output_o == $past(foreground_complete_reg))
    else $error("status pin not foreground complete");
  chk_trig_soft: assert property (!tsel_reg |-> cal_trigger_o == soft_reg)
    else $error("software trigger not routed");
  chk_trig_hw: assert property (tsel_reg |-> cal_trigger_o == hw_trig)
    else $error("hardware trigger not routed");
  chk_reset_vals: assert property ($rose(rst_b_i) |-> (soft_reg && lp_reg == LP_RESET))
    else $error("reset values wrong");
  chk_lp_gate: assert property (!background_calibration_enable_i |-> !lowpower_active_o)
    else $error("low power active without background calibration");

  // Write paths, remaining pin routes and the start pulse
  chk_soft_write: assert property ((wr && idx(paddr_i) == IDX_SOFT) |=> soft_reg == $past(pwdata_i[0]))
    else $error("software trigger write lost");
  chk_lp_write: assert property ((wr && idx(paddr_i) == IDX_LP) |=>
      (lp_reg[2] == 1'b0 && lp_reg[7:3] == $past(pwdata_i[7:3]) && lp_reg[1:0] == $past(pwdata_i[1:0])))
    else $error("low-power write mismatch");
  chk_pin_halt: assert property ((psel_reg == 2'h1) ##1 (psel_reg == 2'h1) |->
      calibration_status_output_o == $past(halted_reg))
    else $error("status pin not background halted");
  chk_pin_alarm: assert property ((psel_reg == 2'h2) ##1 (psel_reg == 2'h2) |->
      calibration_status_output_o == $past(alarm_i))
    else $error("status pin not alarm");
  chk_halt_bg_on: assert property ((background_calibration_enable_i && fg_set &&
      !bg_halt_reached_i && !halted_reg) |=> !halted_reg)
    else $error("halted flag set by foreground with background on");
  chk_calib_pulse: assert property (core_calibrate_o |=> !core_calibrate_o)
    else $error("calibration start longer than one cycle");
endmodule

// File: cst_trig_model.sv
/*
  Far side of the bank: trigger pin source and status pin monitor.
  Assumes the bench asks for a pin level; the model moves it after an edge.
*/
`timescale 1ns/100ps
module cst_trig_model
(
  input  wire logic clk_i,    // Core clock
  input  wire logic rst_b_i,  // Reset, active low
  input  wire logic level_i,  // Requested trigger level
  input  wire logic status_i, // Status pin from the bank
  output logic      pin_o,    // Trigger pin driven to the bank
  output logic      seen_o    // Last status level seen
);
  // Pin moves just after an edge; status sampled each edge
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      pin_o  <= 1'b1;
      seen_o <= 1'b0;
    end
    else
    begin
      pin_o  <= level_i;
      seen_o <= status_i;
    end
endmodule

// File: cst_regs_tb_top.sv
/*
  Self-checking bench for the calibration register bank.
  Assumes small low-power delay units; APB waits follow pready.
*/
`timescale 1ns/100ps
module cst_regs_tb_top;
  import cst_pkg::*;
  logic clk_i, rst_b_i, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, fgc, fgs, fgr, bgh, bgr, bge, alarm, csl;
  logic [2:0] code;
  logic pin, lvl, stat, seen, trig, lpa, asl, irq, cal;
  logic [32:0] eq[$];   // Expected {error, data} per transfer
  int err_count, n_compared, n, s, n_go;
  cst_regs #(.UNIT_CYCLES(4), .EXP_CAP(3)) dut_u (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fg_complete_i(fgc), .fg_skipped_i(fgs),
    .fg_restart_i(fgr), .bg_halt_reached_i(bgh), .bg_resume_i(bgr),
    .background_calibration_enable_i(bge), .cal_state_code_i(code),
    .alarm_i(alarm), .core_sleep_i(csl), .hardware_trigger_input_i(pin),
    .calibration_status_output_o(stat), .cal_trigger_o(trig),
    .lowpower_active_o(lpa), .core_asleep_o(asl), .core_calibrate_o(cal),
    .irq_o(irq));
  cst_trig_model far_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .level_i(lvl),
    .status_i(stat), .pin_o(pin), .seen_o(seen));
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_compared++;
    if (v !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, v);
    end
  endtask
  // One APB transfer; expected answer noted for the monitor
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     input logic er = 1'b0);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwdata <= w ? d : 32'h0000_0000;
    eq.push_back({er, w ? 32'h0000_0000 : d});
    @(posedge clk_i);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Monitor: each completed access takes the oldest note
  always @(posedge clk_i)
    if (psel && pen && pready === 1'b1)
    begin
      chk("pslverr", eq[0][32], pslverr);
      if (!pwr)
        chk("prdata", eq[0][31:0], prdata);
      void'(eq.pop_front());
    end
  // Count calibration start pulses
  always @(posedge clk_i)
    if (cal === 1'b1)
      n_go++;
  // Wait a number of clock edges
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Watchdog
  initial
  begin
    wt(5000);
    err_count++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst_b_i, psel, pen, pwr, fgc, fgs, fgr, bgh, bgr, bge, alarm, csl} = '0;
    paddr = '0;
    pwdata = '0;
    code = 3'h0;
    lvl = 1'b1;
    err_count = 0;
    n_compared = 0;
    n_go = 0;
    wt(10);
    rst_b_i <= 1'b1;
    void'($urandom(32'h17e7bb47));
    code <= 3'($urandom);
    wt(2);
    chk("trig", 1, trig);
    apb(0, IDX_STATE, {27'h0, code, 2'b00});
    apb(0, IDX_PIN, 32'h0000_0000);
    apb(0, IDX_SOFT, 32'h0000_0001);
    apb(0, IDX_LP, 32'h0000_0088);
    apb(1, IDX_LP, 32'h0000_00ff);
    apb(0, IDX_LP, 32'h0000_00fb);
    chk("lpa", 0, lpa);
    bge <= 1'b1;
    wt(1);
    chk("lpa", 1, lpa);
    bge <= 1'b0;
    apb(1, IDX_LP, 32'h0000_0088);
    apb(1, IDX_STATE, 32'h0000_00ff);
    apb(0, IDX_STATE, {27'h0, code, 2'b00});
    apb(0, 10'h3ff, 32'h0000_0000, 1'b1);
    apb(1, IDX_IRQ_MASK, 32'h0000_0007);
    // Skipped foreground with background off sets both flags
    fgs <= 1'b1;
    wt(1);
    fgs <= 1'b0;
    apb(0, IDX_STATE, {27'h0, code, 2'b11});
    chk("irq", 1, irq);
    apb(1, IDX_IRQ_STAT, 32'h0000_0003);
    wt(1);
    chk("irq", 0, irq);
    // Background on: resume clears, foreground end leaves halt alone
    bge <= 1'b1;
    fgr <= 1'b1;
    bgr <= 1'b1;
    wt(1);
    {fgr, bgr} <= 2'b00;
    fgc <= 1'b1;
    wt(1);
    fgc <= 1'b0;
    apb(0, IDX_STATE, {27'h0, code, 2'b01});
    {fgr, bgh} <= 2'b11;
    wt(1);
    {fgr, bgh} <= 2'b00;
    apb(0, IDX_STATE, {27'h0, code, 2'b10});
    // Status pin routing, foreground 0 and halted 1
    alarm <= 1'b1;
    for (s = 0; s < 4; s++)
    begin
      apb(1, IDX_PIN, 32'(s << 1));
      wt(4);
      chk("status", (s == 1 || s == 2) ? 1 : 0, seen);
    end
    // Trigger source selection
    lvl <= 1'b1;
    apb(1, IDX_PIN, 32'h0000_0000);
    apb(1, IDX_SOFT, 32'h0000_0000);
    wt(1);
    chk("trig", 0, trig);
    apb(1, IDX_PIN, 32'h0000_0001);
    wt(6);
    chk("trig", 1, trig);
    lvl <= 1'b0;
    apb(1, IDX_SOFT, 32'h0000_0001);
    wt(6);
    chk("trig", 0, trig);
    lvl <= 1'($urandom);
    apb(1, IDX_PIN, 32'h0000_0000);
    wt(1);
    chk("trig", 1, trig);
    // Trigger-wake low power: asleep until software trigger low
    apb(1, IDX_IRQ_STAT, 32'h0000_0007);
    apb(1, IDX_LP, 32'h0000_0003);
    csl <= 1'b1;
    wt(1);
    csl <= 1'b0;
    wt(60);
    chk("asleep", 1, asl);
    apb(1, IDX_SOFT, 32'h0000_0000);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      wt(1);
      n++;
    end
    chk("irq", 1, irq);
    chk("asleep", 0, asl);
    apb(0, IDX_IRQ_STAT, 32'h0000_0004);
    // Autonomous low power: sleep delay counts, low trigger ignored
    apb(1, IDX_IRQ_STAT, 32'h0000_0007);
    apb(1, IDX_LP, 32'h0000_0001);
    csl <= 1'b1;
    wt(1);
    csl <= 1'b0;
    wt(20);
    chk("asleep", 1, asl);
    wt(20);
    chk("asleep", 0, asl);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      wt(1);
      n++;
    end
    chk("irq", 1, irq);
    chk("calibrate", 2, n_go);
    wt(2);
    tally_and_finish();
  end
endmodule
